// File: hdl/segment_panel_drive_control.sv
// Summary of operation
// - Three-bit duty select: 3 quarter, 2 third, 1 half, 0 static; default 3.
// - All 32 segment lines are driven in every duty setting.
// - Fixed one-third bias with three drive potentials, no bias choice.
// - Thirty-two byte display memory at 0x53C0 to 0x53DF, byte per segment.
// - Memory bit 1 turns its segment on, bit 0 turns it off.
// - Memory low nibble readable and writable for read-modify-write of single bits; upper four bits read 0.
// - Low bits not mapped by the duty are plain storage, no panel effect.
// - Display state: 0 off, 1 normal, 2 all on, 3 all off.
// - Display off stops the supply and grounds all three bias pins.
// - All on and all off change only the waveform, never memory.
// - All on keeps dynamic commons; all off drives commons statically.
// - Reset clears the display state to off.
// - Sleep forces state off; waking restores the state held before sleep, or the one written while asleep.
// - Reverse bit 0 inverts every segment, 1 gives normal polarity.
// - Inversion acts only in the output path, never on memory.
// - Inversion ignored in all off; in all on it blanks everything.
// - Frame derived from base clock by duty-dependent 2-bit divider.
// - Clock gate bit, default stopped, feeds the base clock to the drive.
`timescale 1ns/1ps
`default_nettype none
`include "panel_map.svh"

module segment_panel_drive_control
  import panel_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Panel base clock from outside the domain.
  input  wire logic              i_panel_base_clock,
  // Drive control fields.
  input  wire logic              i_panel_clock_gate,
  input  wire logic [2:0]        i_drive_duty_select,
  input  wire logic [1:0]        i_frame_divide_select,
  input  wire logic              i_invert_display_n,
  // Display state field write and readback.
  input  wire logic              i_display_state_wr,
  input  wire logic [1:0]        i_display_state_select,
  output logic      [1:0]        o_display_state_select,
  // Sleep entry and exit pulses.
  input  wire logic              i_sleep_enter,
  input  wire logic              i_sleep_exit,
  // Display memory access.
  input  wire logic [15:0]       i_mem_addr,
  input  wire logic              i_mem_wr,
  input  wire logic [7:0]        i_mem_wdata,
  input  wire logic              i_mem_rd,
  output logic      [7:0]        o_mem_rdata,
  // Panel drive.
  output logic                   o_bias_enable,
  output logic      [3:0][1:0]   o_common_level,
  output logic      [31:0][1:0]  o_segment_level,
  output logic                   o_frame_phase
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Maps the two-bit state field to a one-hot mode.
  function automatic mode_t decode_mode(input logic [1:0] sel);
    mode_t m;
    m = MODE_OFF;
    case (sel)
      `DSTATE_NORMAL:  m = MODE_NORMAL;
      `DSTATE_ALL_ON:  m = MODE_ALL_ON;
      `DSTATE_ALL_OFF: m = MODE_ALL_OFF;
      default:         m = MODE_OFF;
    endcase
    return m;
  endfunction : decode_mode

  // Number of active commons per duty; reserved codes run as quarter duty.
  function automatic logic [2:0] com_count(input logic [2:0] duty);
    logic [2:0] n;
    n = 3'h4;
    case (duty)
      `DUTY_STATIC: n = 3'h1;
      `DUTY_HALF:   n = 3'h2;
      `DUTY_THIRD:  n = 3'h3;
      default:      n = 3'h4;
    endcase
    return n;
  endfunction : com_count

  // Base clock ticks per common slot: frame length divided by active commons.
  // Third duty needs a true divide by three; the other duties only shift.
  function automatic logic [4:0] slot_len(input logic [2:0] duty, input logic [1:0] fsel);
    logic [4:0] frame;
    logic [4:0] len;
    frame = (duty == `DUTY_THIRD) ?
            `FRM_THIRD_BASE + {2'h0, fsel, 1'b0} + {3'h0, fsel} :
            ({3'h0, fsel} + 5'h01) * `FRM_STD_STEP;
    len   = frame >> 2;
    case (duty)
      `DUTY_STATIC: len = frame;
      `DUTY_HALF:   len = frame >> 1;
      `DUTY_THIRD:  len = frame / 5'h03;
      default:      len = frame >> 2;
    endcase
    return len;
  endfunction : slot_len

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  top_state_t       state_reg;
  top_state_t       state_next;
  logic [31:0][3:0] cells;
  logic [1:0]       com_idx;
  logic             phase;
  logic [2:0]       n_com;
  mode_t            mode;
  logic             lit;

  assign n_com = com_count(i_drive_duty_select);
  assign mode  = decode_mode(state_reg.disp_sel);

  // Memory is written only through its own port; the waveform path reads it.
  display_memory u_mem (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_addr  (i_mem_addr),
    .i_wr    (i_mem_wr),
    .i_wdata (i_mem_wdata),
    .i_rd    (i_mem_rd),
    .o_rdata (o_mem_rdata),
    .o_cells (cells)
  );

  // Frame timing advances only on gated base clock ticks.
  frame_divider u_div (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_tick      (state_reg.tick),
    .i_slot_len  (slot_len(i_drive_duty_select, i_frame_divide_select)),
    .i_com_count (n_com),
    .o_com_idx   (com_idx),
    .o_phase     (phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Base clock edge detection and the display state register.

  always_comb begin
    state_next = state_reg;
    lit        = 1'b0;
    // Three stages; only the agreeing second and third stages count, so a
    // metastable first stage never reaches the edge logic.
    state_next.sync = {state_reg.sync[1:0], i_panel_base_clock};
    state_next.tick = 1'b0;
    if (state_reg.sync[1] == state_reg.sync[2]) begin
      state_next.clk_lvl = state_reg.sync[2];
      state_next.tick    = state_reg.sync[2] & ~state_reg.clk_lvl & i_panel_clock_gate;
    end

    // A write during sleep lands in the saved copy so wake-up shows it.
    if (i_display_state_wr) begin
      if (state_reg.asleep) begin
        state_next.saved_sel = i_display_state_select;
      end else begin
        state_next.disp_sel = i_display_state_select;
      end
    end
    // Sleep wins over a same-cycle write, which is saved for wake; while asleep a same-cycle wake wins.
    if (i_sleep_enter && !state_reg.asleep) begin
      state_next.saved_sel = i_display_state_wr ? i_display_state_select
                                                : state_reg.disp_sel;
      state_next.disp_sel  = `DSTATE_OFF;
      state_next.asleep    = 1'b1;
    end else if (i_sleep_exit && state_reg.asleep) begin
      state_next.disp_sel  = i_display_state_wr ? i_display_state_select
                                                : state_reg.saved_sel;
      state_next.asleep    = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Waveform: common selected V3/V0, unselected V1/V2; segment on V0/V3,
    // off V2/V1. Every line swings by one third except a lit crossing.
    state_next.bias_on = (mode != MODE_OFF);
    for (int c = 0; c < 4; c++) begin
      state_next.com_level[c] = `LVL_VSS;
    end
    for (int s = 0; s < 32; s++) begin
      state_next.seg_level[s] = `LVL_VSS;
    end
    unique case (mode)
      MODE_OFF: begin
        // Supply stopped, every line at ground.
        // Ground on every line leaves no voltage across any cell while dark.
        state_next.bias_on = 1'b0;
      end
      MODE_ALL_OFF: begin
        // Commons go static and segments copy them: no voltage anywhere,
        // and inversion has nothing to act on.
        for (int c = 0; c < 4; c++) begin
          state_next.com_level[c] = phase ? `LVL_BIAS3 : `LVL_VSS;
        end
        for (int s = 0; s < 32; s++) begin
          state_next.seg_level[s] = phase ? `LVL_BIAS3 : `LVL_VSS;
        end
      end
      MODE_NORMAL, MODE_ALL_ON: begin
        for (int c = 0; c < 4; c++) begin
          if (c == int'(com_idx)) begin
            state_next.com_level[c] = phase ? `LVL_BIAS3 : `LVL_VSS;
          end else begin
            state_next.com_level[c] = phase ? `LVL_BIAS1 : `LVL_BIAS2;
          end
        end
        for (int s = 0; s < 32; s++) begin
          lit = (mode == MODE_ALL_ON) ? 1'b1 : cells[s][com_idx];
          lit = lit ^ ~i_invert_display_n;
          if (lit) begin
            state_next.seg_level[s] = phase ? `LVL_VSS : `LVL_BIAS3;
          end else begin
            state_next.seg_level[s] = phase ? `LVL_BIAS2 : `LVL_BIAS1;
          end
        end
      end
    endcase
  end

  // Single register bank for all controller state.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg          <= '0;
      state_reg.disp_sel <= `DSTATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_display_state_select = state_reg.disp_sel;
  assign o_bias_enable          = state_reg.bias_on;
  assign o_common_level         = state_reg.com_level;
  assign o_segment_level        = state_reg.seg_level;
  assign o_frame_phase          = phase;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Every level is registered, so each consequent looks one cycle after its cause
  // (the bias check after sleep two) and reads the cause's phase and slot through $past.

  reset_state_off_a: assert property (
    @(posedge i_clk)
    i_rst |=> (o_display_state_select == `DSTATE_OFF))
    else $error("display state not off after reset");

  sleep_forces_off_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_sleep_enter && !state_reg.asleep) |=> (o_display_state_select == `DSTATE_OFF)
      ##1 (o_bias_enable == 1'b0))
    else $error("sleep did not force the display off");

  wake_restores_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_sleep_exit && state_reg.asleep && !i_sleep_enter && !i_display_state_wr)
      |=> (o_display_state_select == $past(state_reg.saved_sel)))
    else $error("wake did not restore the saved display state");

  off_grounds_lines_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_OFF) |=> (!o_bias_enable && (o_common_level == '0)
      && (o_segment_level == '0)))
    else $error("display off left bias or lines driven");

  all_off_static_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_ALL_OFF) |=> (o_common_level == {4{o_common_level[0]}})
      && (o_segment_level == {32{o_common_level[0]}}))
    else $error("all off did not drive static blank lines");

  all_on_inverted_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_ALL_ON && !i_invert_display_n)
      |=> (o_segment_level == {32{$past(phase) ? `LVL_BIAS2 : `LVL_BIAS1}}))
    else $error("inverted all on did not blank the segments");

  normal_shows_bit_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_NORMAL && i_invert_display_n && cells[0][com_idx])
      |=> (o_segment_level[0] == ($past(phase) ? `LVL_VSS : `LVL_BIAS3)))
    else $error("set memory bit did not light its segment");

  normal_inverted_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_NORMAL && !i_invert_display_n && cells[0][com_idx])
      |=> (o_segment_level[0] == ($past(phase) ? `LVL_BIAS2 : `LVL_BIAS1)))
    else $error("inverted display lit a set memory bit");

  all_on_dynamic_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode == MODE_ALL_ON) |=> ((o_common_level[$past(com_idx)]
      == ($past(phase) ? `LVL_BIAS3 : `LVL_VSS)) && (o_common_level[2'($past(com_idx) + 2'h1)]
      == ($past(phase) ? `LVL_BIAS1 : `LVL_BIAS2))))
    else $error("all on did not keep the commons multiplexed");

  bias_on_shown_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (mode != MODE_OFF) |=> (o_bias_enable == 1'b1))
    else $error("bias supply off while a display mode is selected");

endmodule : segment_panel_drive_control
`default_nettype wire

// File: hdl/panel_map.svh
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH

// Display memory window, byte addresses.
`define MEM_BASE_ADDR   16'h53C0
`define MEM_LAST_ADDR   16'h53DF
`define MEM_DEPTH       32
`define MEM_CELL_BITS   4

// Drive duty codes.
`define DUTY_STATIC     3'h0
`define DUTY_HALF       3'h1
`define DUTY_THIRD      3'h2
`define DUTY_QUARTER    3'h3
`define DUTY_RESET      3'h3

// Display state codes.
`define DSTATE_OFF      2'h0
`define DSTATE_NORMAL   2'h1
`define DSTATE_ALL_ON   2'h2
`define DSTATE_ALL_OFF  2'h3
`define DSTATE_RESET    2'h0

// Reset values of the software controls held outside this block.
`define INVERT_N_RESET  1'b1
`define FRAME_DIV_RESET 2'h1
`define CLK_GATE_RESET  1'b0

// Frame length in base clock ticks: standard 4,8,12,16; third duty 6,9,12,15.
`define FRM_STD_STEP    5'h04
`define FRM_THIRD_BASE  5'h06

// Drive potential codes on a line: ground and the three bias levels.
`define LVL_VSS         2'h0
`define LVL_BIAS1       2'h1
`define LVL_BIAS2       2'h2
`define LVL_BIAS3       2'h3

`endif

// File: hdl/panel_pkg.sv
`default_nettype none

package panel_pkg;

  // Decoded display state, one-hot.
  typedef enum logic [3:0] {
    MODE_OFF     = 4'b0001,
    MODE_NORMAL  = 4'b0010,
    MODE_ALL_ON  = 4'b0100,
    MODE_ALL_OFF = 4'b1000
  } mode_t;

  // State of the display memory.
  typedef struct packed {
    logic [31:0][3:0] cells;
    logic [7:0]       rdata;
  } mem_state_t;

  // State of the frame divider.
  typedef struct packed {
    logic [4:0] cnt;
    logic [1:0] com;
    logic       phase;
  } div_state_t;

  // State of the drive controller.
  typedef struct packed {
    logic [2:0]        sync;
    logic              clk_lvl;
    logic              tick;
    logic [1:0]        disp_sel;
    logic [1:0]        saved_sel;
    logic              asleep;
    logic              bias_on;
    logic [3:0][1:0]   com_level;
    logic [31:0][1:0]  seg_level;
  } top_state_t;

endpackage : panel_pkg
`default_nettype wire

// File: hdl/display_memory.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_map.svh"

module display_memory
  import panel_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Byte access port.
  input  wire logic [15:0]      i_addr,
  input  wire logic             i_wr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  // Cell contents seen by the waveform logic.
  output logic      [31:0][3:0] o_cells
);

  mem_state_t state_reg;
  mem_state_t state_next;
  logic       hit;
  logic [4:0] idx;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: only the 32-byte window answers.
  assign hit = (i_addr >= `MEM_BASE_ADDR) && (i_addr <= `MEM_LAST_ADDR);
  assign idx = i_addr[4:0];

  // Reads return the stored low nibble; the upper bits do not exist.
  always_comb begin
    state_next = state_reg;
    if (i_wr && hit) begin
      state_next.cells[idx] = i_wdata[3:0];
    end
    if (i_rd) begin
      state_next.rdata = hit ? {4'h0, state_reg.cells[idx]} : 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_cells = state_reg.cells;

  ////////////////////////////////////////////////////////////////////////////
  mem_write_store_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && hit) |=> (state_reg.cells[$past(idx)] == $past(i_wdata[3:0])))
    else $error("display memory write was not stored");

  unmapped_read_zero_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && !hit) |=> (o_rdata == 8'h00))
    else $error("read outside the memory window did not return zero");

endmodule : display_memory
`default_nettype wire

// File: hdl/frame_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_map.svh"

module frame_divider
  import panel_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Base clock tick and slot shape.
  input  wire logic       i_tick,
  input  wire logic [4:0] i_slot_len,
  input  wire logic [2:0] i_com_count,
  // Current common slot and frame polarity.
  output logic      [1:0] o_com_idx,
  output logic            o_phase
);

  div_state_t state_reg;
  div_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Each common gets an equal slot; the polarity flips once per frame.
  // Compares use >= so a duty change mid-frame cannot run a counter past its end.
  always_comb begin
    state_next = state_reg;
    if (i_tick) begin
      if ({1'b0, state_reg.com} >= i_com_count) begin
        // A cut in duty left the slot past the last active common: restart
        // the frame at common 0 rather than drive a dead line for a slot.
        state_next.cnt = 5'h00;
        state_next.com = 2'h0;
      end else if (state_reg.cnt >= i_slot_len - 5'h01) begin
        state_next.cnt = 5'h00;
        if ({1'b0, state_reg.com} >= i_com_count - 3'h1) begin
          state_next.com   = 2'h0;
          state_next.phase = ~state_reg.phase;
        end else begin
          state_next.com = state_reg.com + 2'h1;
        end
      end else begin
        state_next.cnt = state_reg.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_com_idx = state_reg.com;
  assign o_phase   = state_reg.phase;

  ////////////////////////////////////////////////////////////////////////////
  frozen_without_tick_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_tick |=> ($stable(o_com_idx) && $stable(o_phase)))
    else $error("divider advanced without a base clock tick");

  slot_in_range_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_tick && $stable(i_com_count)) |=> ({1'b0, o_com_idx} < $past(i_com_count)))
    else $error("common slot index beyond the active commons");

endmodule : frame_divider
`default_nettype wire

// File: tb/panel_model.sv
`timescale 1ns/1ps
`default_nettype none

module panel_model (
  // Drive lines from the block.
  input  wire logic             i_bias_enable,
  input  wire logic [3:0][1:0]  i_common_level,
  input  wire logic [31:0][1:0] i_segment_level,
  // What the glass shows.
  output logic      [3:0]       o_selected,
  output logic      [31:0][3:0] o_lit
);

  // A cell darkens only under the full three-step swing; smaller swings stay clear.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      o_selected[c] = i_bias_enable && (i_common_level[c] == 2'h0 || i_common_level[c] == 2'h3);
      for (int s = 0; s < 32; s++) begin
        o_lit[s][c] = i_bias_enable &&
          ((i_common_level[c] == 2'h0 && i_segment_level[s] == 2'h3) ||
           (i_common_level[c] == 2'h3 && i_segment_level[s] == 2'h0));
      end
    end
  end

endmodule : panel_model
`default_nettype wire

// File: tb/segment_panel_drive_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module segment_panel_drive_control_tb;
  logic              i_clk = 1'b0;
  logic              i_rst, i_panel_clock_gate, i_invert_display_n;
  logic              i_panel_base_clock = 1'b0;
  logic [2:0]        i_drive_duty_select;
  logic [1:0]        i_frame_divide_select, i_display_state_select, o_display_state_select;
  logic              i_display_state_wr, i_sleep_enter, i_sleep_exit, i_mem_wr, i_mem_rd;
  logic [15:0]       i_mem_addr;
  logic [7:0]        i_mem_wdata, o_mem_rdata;
  logic              o_bias_enable, o_frame_phase;
  logic [3:0][1:0]   o_common_level;
  logic [31:0][1:0]  o_segment_level;
  logic [3:0]        sel;
  logic [31:0][3:0]  lit;
  logic [1:0]        base_div = 2'h0;
  int                bad_count = 0, tests_run = 0, cycles = 0;

  segment_panel_drive_control i_segment_panel_drive_control (.*);
  panel_model i_panel_model (.i_bias_enable(o_bias_enable), .i_common_level(o_common_level),
    .i_segment_level(o_segment_level), .o_selected(sel), .o_lit(lit));

  ////////////////////////////////////////////////////////////////////////////////
  // System clock; the base clock runs free at one eighth of it so a normal display stays lit.
  always #10 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    base_div <= base_div + 2'h1;
    if (base_div == 2'h3) i_panel_base_clock <= ~i_panel_base_clock;
  end

  // A hang is cut short well past the few thousand cycles the tests need.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] pat(input int s);
    return 4'(s * 7 + 3);
  endfunction : pat

  function automatic logic [31:0][3:0] image(input logic inv);
    logic [31:0][3:0] m;
    for (int s = 0; s < 32; s++) m[s] = inv ? ~pat(s) : pat(s);
    return m;
  endfunction : image

  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_mem_addr = a; i_mem_wdata = d; i_mem_wr = 1'b1;
    @(negedge i_clk);
    i_mem_wr = 1'b0;
  endtask : mem_wr

  // The read data stands until the next read, so it is taken a full cycle later.
  task automatic mem_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_clk);
    i_mem_addr = a; i_mem_rd = 1'b1;
    @(negedge i_clk);
    i_mem_rd = 1'b0;
    @(negedge i_clk);
    d = o_mem_rdata;
  endtask : mem_rd

  task automatic set_state(input logic [1:0] s);
    @(negedge i_clk);
    i_display_state_select = s; i_display_state_wr = 1'b1;
    @(negedge i_clk);
    i_display_state_wr = 1'b0;
    repeat (40) @(negedge i_clk);
  endtask : set_state

  // Watches several frames: which commons get selected, how many at once, what is lit.
  task automatic observe(input logic [31:0][3:0] exp, input logic [3:0] mask, input int most);
    logic [3:0] seen;
    int errs, peak;
    seen = 4'h0; errs = 0; peak = 0;
    repeat (300) begin
      @(negedge i_clk);
      seen |= sel;
      if ($countones(sel) > peak) peak = $countones(sel);
      for (int c = 0; c < 4; c++)
        if (sel[c]) for (int s = 0; s < 32; s++) if (lit[s][c] !== exp[s][c]) errs++;
    end
    `CHK(seen, mask)
    `CHK(errs, 0)
    `CHK(peak, most)
  endtask : observe

  task automatic phase_gap(output int n);
    logic p;
    p = o_frame_phase; n = 0;
    while (o_frame_phase === p && n < 400) begin
      @(negedge i_clk);
      n++;
    end
  endtask : phase_gap

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK(o_display_state_select, 2'h0)
    `CHK(o_bias_enable, 1'b0)
    `CHK(o_common_level, 8'h00)
    $display("test reset done");
  endtask : t_reset

  task automatic t_memory;
    logic [7:0] d;
    for (int s = 0; s < 32; s++) mem_wr(16'h53C0 + 16'(s), {4'hA, pat(s)});
    for (int s = 0; s < 32; s++) begin
      mem_rd(16'h53C0 + 16'(s), d);
      `CHK(d, {4'h0, pat(s)})
    end
    mem_wr(16'h53E0, 8'hFF);
    mem_rd(16'h53E0, d);
    `CHK(d, 8'h00)
    mem_rd(16'h53C5, d);
    mem_wr(16'h53C5, d ^ 8'h08);
    mem_rd(16'h53C5, d);
    `CHK(d, {4'h0, pat(5) ^ 4'h8})
    mem_wr(16'h53C5, {4'h0, pat(5)});
    $display("test memory done");
  endtask : t_memory

  // Every duty drives all segments; unmapped low bits never reach the glass.
  task automatic t_duty;
    logic [3:0] masks [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
    i_panel_clock_gate = 1'b1;
    set_state(2'h1);
    for (int d = 0; d < 4; d++) begin
      i_drive_duty_select = 3'(d);
      repeat (60) @(negedge i_clk);
      observe(image(1'b0), masks[d], 1);
    end
    i_drive_duty_select = 3'h5;
    repeat (60) @(negedge i_clk);
    observe(image(1'b0), 4'hF, 1);
    i_drive_duty_select = 3'h3;
    $display("test duty done");
  endtask : t_duty

  task automatic t_invert;
    logic [7:0] d;
    i_invert_display_n = 1'b0;
    repeat (40) @(negedge i_clk);
    observe(image(1'b1), 4'hF, 1);
    mem_rd(16'h53C9, d);
    `CHK(d, {4'h0, pat(9)})
    i_invert_display_n = 1'b1;
    $display("test invert done");
  endtask : t_invert

  task automatic t_flash;
    logic [7:0] d;
    set_state(2'h2);
    observe('1, 4'hF, 1);
    i_invert_display_n = 1'b0;
    repeat (40) @(negedge i_clk);
    observe('0, 4'hF, 1);
    set_state(2'h3);
    observe('0, 4'hF, 4);
    i_invert_display_n = 1'b1;
    mem_rd(16'h53D3, d);
    `CHK(d, {4'h0, pat(19)})
    $display("test flash done");
  endtask : t_flash

  task automatic t_sleep;
    set_state(2'h2);
    // First pass wakes to the state held before sleep; second writes while asleep.
    for (int k = 0; k < 2; k++) begin
      @(negedge i_clk) i_sleep_enter = 1'b1;
      @(negedge i_clk) i_sleep_enter = 1'b0;
      repeat (3) @(negedge i_clk);
      `CHK(o_display_state_select, 2'h0)
      `CHK(o_bias_enable, 1'b0)
      if (k == 1) set_state(2'h1);
      `CHK(o_display_state_select, 2'h0)
      @(negedge i_clk) i_sleep_exit = 1'b1;
      @(negedge i_clk) i_sleep_exit = 1'b0;
      repeat (3) @(negedge i_clk);
      `CHK(o_display_state_select, (k == 1) ? 2'h1 : 2'h2)
    end
    $display("test sleep done");
  endtask : t_sleep

  // Frame length in system cycles is the tick count times the eight-cycle base period.
  task automatic t_frames;
    int n;
    for (int t = 0; t < 2; t++) begin
      for (int f = 0; f < 4; f++) begin
        i_drive_duty_select = t ? 3'h2 : 3'h3;
        i_frame_divide_select = 2'(f);
        phase_gap(n);
        phase_gap(n);
        phase_gap(n);
        `CHK(n, t ? (6 + 3 * f) * 8 : (f + 1) * 32)
      end
    end
    $display("test frames done");
  endtask : t_frames

  task automatic t_freeze;
    logic [31:0][1:0] segs;
    logic [3:0][1:0]  coms;
    logic             ph;
    i_panel_clock_gate = 1'b0;
    repeat (20) @(negedge i_clk);
    segs = o_segment_level; coms = o_common_level; ph = o_frame_phase;
    repeat (200) @(negedge i_clk);
    `CHK({segs, coms, ph}, {o_segment_level, o_common_level, o_frame_phase})
    i_panel_clock_gate = 1'b1;
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_off;
    set_state(2'h0);
    `CHK(o_bias_enable, 1'b0)
    `CHK({o_common_level, o_segment_level}, 72'h0)
    $display("test off done");
  endtask : t_off

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is held for twenty cycles first.
  initial begin
    i_rst = 1'b1; i_panel_clock_gate = 1'b0;
    i_drive_duty_select = 3'h3; i_frame_divide_select = 2'h1; i_invert_display_n = 1'b1;
    i_display_state_wr = 1'b0; i_display_state_select = 2'h0;
    i_sleep_enter = 1'b0; i_sleep_exit = 1'b0;
    i_mem_addr = 16'h0000; i_mem_wr = 1'b0; i_mem_wdata = 8'h00; i_mem_rd = 1'b0;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_memory();
    t_duty();
    t_invert();
    t_flash();
    t_sleep();
    t_frames();
    t_freeze();
    t_off();
    complete_run();
  end

endmodule : segment_panel_drive_control_tb
`default_nettype wire
